// ==== hdl/uartdp_top.sv ====
// UART channel serial datapath: transmit path, receive path, IR, RS-485, loopback
// Summary of operation
// - Send start, data LSB first, parity, stop
// - FIFO mode: holding writes queue 128 bytes
// - Non-FIFO: holding-empty sets on shifter load
// - FIFO mode: holding-empty set while FIFO empty
// - Holding-empty interrupt only when enabled
// - Transmitter-empty once shifter and FIFO empty
// - Start bit rechecked low after 8 samples
// - Data and stop sampled at bit centre
// - Entries carry three tags shown for head
// - Data-ready interrupt per char or trigger
// - Timeout after 4 words plus 12 bits
// - Auto direction drops after last stop
// - Auto direction rises first, polarity selectable
// - Multidrop: parity position is address flag
// - Auto address drops unmatched address and data
// - Matched address stored tagged, line interrupt
// - IR encoder: 3/16 pulse per zero
// - IR enable and idle level controls
// - IR light pulse decodes as zero
// - Loopback: tx into rx, outputs held idle except IR out
// - Reset returns registers and outputs to defaults
// - 16x sampling tick from divisor
`timescale 1ns/1ps
`include "uartdp_regs.svh"
module uartdp_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Host data port
  input wire logic thr_wr_i,
  input wire logic [7:0] thr_data_i,
  output logic tx_holding_ready_o,
  input wire logic rhr_rd_i,
  output logic [7:0] rx_holding_o,
  input wire logic lsr_rd_i,
  // Configuration levels
  input wire logic [7:0] fifo_control_i,
  input wire logic [7:0] line_control_i,
  input wire logic [7:0] interrupt_enable_i,
  input wire logic [7:0] modem_control_i,
  input wire logic [7:0] multifunction_i,
  input wire logic [7:0] ir_control_i,
  input wire logic [7:0] slave_addr_i,
  input wire logic [15:0] divisor_i,
  input wire logic [7:0] rx_trigger_i,
  // Status
  output logic [7:0] line_status_o,
  output logic [3:0] interrupt_status_o,
  output logic irq_o,
  // Serial side
  input wire logic rx_i,
  output logic tx_o,
  input wire logic ir_rx_in_i,
  output logic ir_tx_out_o,
  output logic direction_out_o,
  output logic dtr_o,
  // Modem inputs
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic carrier_in_i,
  input wire logic ring_in_i,
  output logic [3:0] modem_status_o
);
  // Index of the last data bit for the word length field
  function automatic logic [2:0] last_bit(input logic [7:0] line_control);
    last_bit = {1'b0, line_control[1:0]} + `UDP_MIN_BITS;
  endfunction : last_bit

  // Parity or address bit for a character
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] line_control, input logic md);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - line_control[1:0]);
    if (md) par_of = line_control[`UDP_LCR_EVEN];
    else if (line_control[`UDP_LCR_FORCE]) par_of = ~line_control[`UDP_LCR_EVEN];
    else par_of = (^(d & m)) ^ ~line_control[`UDP_LCR_EVEN];
  endfunction : par_of

  logic fifo_en;
  logic loop_en;
  logic ir_en;
  logic mdrop;
  logic aad_en;
  logic auto_en;
  assign fifo_en = fifo_control_i[`UDP_FCR_EN];
  assign loop_en = modem_control_i[`UDP_MCR_LOOP];
  assign ir_en = ir_control_i[`UDP_IRC_EN];
  assign mdrop = multifunction_i[`UDP_EMF_MDROP];
  assign aad_en = multifunction_i[`UDP_EMF_AAD] && mdrop;
  assign auto_en = multifunction_i[`UDP_EMF_AUTO];

  // Sampling tick; divisor of zero behaves as one
  logic [15:0] div_cnt_r;
  logic [15:0] div_last;
  logic tick;
  assign div_last = (divisor_i == 16'h0000) ? 16'h0000 : divisor_i - 16'h0001;
  assign tick = (div_cnt_r >= div_last);
  always_ff @(posedge core_clk_i) begin
    if (rst_i || tick) div_cnt_r <= 16'h0000;
    else div_cnt_r <= div_cnt_r + 16'h0001;
  end

  // Transmit FIFO; non-FIFO mode caps it at one entry
  logic tx_in_ready;
  logic tx_out_valid;
  logic tx_pop;
  logic tx_push;
  logic [7:0] tx_head;
  logic [`UDP_CNT_W-1:0] tx_count;
  logic tx_accept;
  assign tx_accept = tx_in_ready && (fifo_en || tx_count == '0);
  assign tx_push = thr_wr_i && tx_accept;
  uartdp_fifo #(.WIDTH(`UDP_TX_W), .DEPTH(`UDP_FIFO_DEPTH)) u_tx_fifo (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_in_ready),
    .in_data_i(thr_data_i),
    .out_valid_o(tx_out_valid),
    .out_ready_i(tx_pop),
    .out_data_o(tx_head),
    .count_o(tx_count)
  );

  // Transmit shifter state
  uartdp_pkg::uartdp_ser_state_t tx_state_r;
  logic [3:0] tx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_shifter_r;
  logic tx_par_r;
  logic tx_stop2_r;
  logic dir_act_r;
  logic tx_line;
  logic tx_bit_end;

  // Auto direction must already be up one cycle before a byte is taken
  assign tx_pop = (tx_state_r == uartdp_pkg::UDP_IDLE) && tx_out_valid
                  && (!auto_en || dir_act_r);
  assign tx_bit_end = tick && (tx_cnt_r == `UDP_OVS_LAST);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_state_r <= uartdp_pkg::UDP_IDLE;
      tx_cnt_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_shifter_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_stop2_r <= 1'b0;
    end else begin
      if (tick) tx_cnt_r <= tx_cnt_r + 4'h1;
      case (tx_state_r)
        uartdp_pkg::UDP_IDLE: begin
          if (tx_pop) begin
            tx_shifter_r <= tx_head;
            tx_par_r <= par_of(tx_head, line_control_i, mdrop);
            tx_cnt_r <= 4'h0;
            tx_state_r <= uartdp_pkg::UDP_START;
          end
        end
        uartdp_pkg::UDP_START: begin
          if (tx_bit_end) begin
            tx_bit_r <= 3'h0;
            tx_state_r <= uartdp_pkg::UDP_DATA;
          end
        end
        uartdp_pkg::UDP_DATA: begin
          if (tx_bit_end) begin
            tx_shifter_r <= {1'b0, tx_shifter_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == last_bit(line_control_i)) begin
              tx_stop2_r <= line_control_i[`UDP_LCR_STOP];
              tx_state_r <= (line_control_i[`UDP_LCR_PEN] || mdrop) ?
                            uartdp_pkg::UDP_PARITY : uartdp_pkg::UDP_STOP;
            end
          end
        end
        uartdp_pkg::UDP_PARITY: begin
          if (tx_bit_end) begin
            tx_stop2_r <= line_control_i[`UDP_LCR_STOP];
            tx_state_r <= uartdp_pkg::UDP_STOP;
          end
        end
        uartdp_pkg::UDP_STOP: begin
          if (tx_bit_end) begin
            if (tx_stop2_r) tx_stop2_r <= 1'b0;
            else tx_state_r <= uartdp_pkg::UDP_IDLE;
          end
        end
        default: tx_state_r <= uartdp_pkg::UDP_IDLE;
      endcase
    end
  end

  // Line level for the current bit
  always_comb begin
    case (tx_state_r)
      uartdp_pkg::UDP_START: tx_line = 1'b0;
      uartdp_pkg::UDP_DATA: tx_line = tx_shifter_r[0];
      uartdp_pkg::UDP_PARITY: tx_line = tx_par_r;
      default: tx_line = 1'b1;
    endcase
  end

  // Direction stays up while anything is queued or shifting
  always_ff @(posedge core_clk_i) begin
    if (rst_i) dir_act_r <= 1'b0;
    else dir_act_r <= (tx_state_r != uartdp_pkg::UDP_IDLE) || tx_out_valid;
  end

  // IR decoder: stretch each light pulse for a bit time so the centre sample sees it
  logic ir_pulse;
  logic [4:0] ir_hold_r;
  logic ir_dec;
  assign ir_pulse = ir_rx_in_i ^ ir_control_i[`UDP_IRC_RXIDLE];
  assign ir_dec = !(ir_pulse || ir_hold_r != 5'h00);
  always_ff @(posedge core_clk_i) begin
    if (rst_i) ir_hold_r <= 5'h00;
    else if (ir_pulse) ir_hold_r <= `UDP_IR_HOLD;
    else if (tick && ir_hold_r != 5'h00) ir_hold_r <= ir_hold_r - 5'h01;
  end

  // Receive input select; rx pin is ignored in loopback
  logic rx_src;
  logic rx_prev_r;
  always_comb begin
    if (loop_en) rx_src = tx_line;
    else if (ir_en) rx_src = ir_dec;
    else rx_src = rx_i;
  end

  // Receive shifter state
  uartdp_pkg::uartdp_ser_state_t rx_state_r;
  logic [3:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_shifter_r;
  logic rx_par_r;
  logic addr_ok_r;
  logic rx_done;
  logic rx_mid;
  assign rx_mid = tick && (rx_cnt_r == `UDP_OVS_LAST);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) rx_prev_r <= 1'b1;
    else rx_prev_r <= rx_src;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_state_r <= uartdp_pkg::UDP_IDLE;
      rx_cnt_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_shifter_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else begin
      if (tick) rx_cnt_r <= rx_cnt_r + 4'h1;
      case (rx_state_r)
        uartdp_pkg::UDP_IDLE: begin
          if (rx_prev_r && !rx_src) begin
            rx_cnt_r <= 4'h0;
            rx_shifter_r <= 8'h00;
            rx_par_r <= 1'b0;
            rx_state_r <= uartdp_pkg::UDP_START;
          end
        end
        uartdp_pkg::UDP_START: begin
          if (tick && rx_cnt_r == `UDP_MID_START) begin
            rx_cnt_r <= 4'h0;
            rx_bit_r <= 3'h0;
            // A glitch that is high again at mid-bit is no start
            rx_state_r <= rx_src ? uartdp_pkg::UDP_IDLE : uartdp_pkg::UDP_DATA;
          end
        end
        uartdp_pkg::UDP_DATA: begin
          if (rx_mid) begin
            rx_shifter_r[rx_bit_r] <= rx_src;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit(line_control_i)) begin
              rx_state_r <= (line_control_i[`UDP_LCR_PEN] || mdrop) ?
                            uartdp_pkg::UDP_PARITY : uartdp_pkg::UDP_STOP;
            end
          end
        end
        uartdp_pkg::UDP_PARITY: begin
          if (rx_mid) begin
            rx_par_r <= rx_src;
            rx_state_r <= uartdp_pkg::UDP_STOP;
          end
        end
        uartdp_pkg::UDP_STOP: begin
          if (rx_mid) rx_state_r <= uartdp_pkg::UDP_IDLE;
        end
        default: rx_state_r <= uartdp_pkg::UDP_IDLE;
      endcase
    end
  end

  // Character completion and its tags
  logic is_addr;
  logic addr_match;
  logic keep;
  logic tag_pe;
  logic tag_fe;
  logic tag_bi;
  logic [10:0] rx_entry;
  assign rx_done = (rx_state_r == uartdp_pkg::UDP_STOP) && rx_mid;
  assign is_addr = mdrop && rx_par_r;
  assign addr_match = (rx_shifter_r == slave_addr_i);
  // Unmatched address and everything after it up to the next matching address is thrown away
  assign keep = !aad_en || (is_addr ? addr_match : addr_ok_r);
  assign tag_pe = mdrop ? rx_par_r :
                  (line_control_i[`UDP_LCR_PEN] &&
                   (rx_par_r != par_of(rx_shifter_r, line_control_i, 1'b0)));
  assign tag_fe = !rx_src;
  assign tag_bi = !rx_src && rx_shifter_r == 8'h00 && !rx_par_r;
  assign rx_entry = {tag_bi, tag_fe, tag_pe, rx_shifter_r};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) addr_ok_r <= 1'b0;
    else if (rx_done && aad_en && is_addr) addr_ok_r <= addr_match;
  end

  // Receive FIFO; a full FIFO keeps its entries and flags overrun
  logic rx_in_ready;
  logic rx_out_valid;
  logic rx_push;
  logic rx_accept;
  logic rx_overrun;
  logic [10:0] rx_head;
  logic [`UDP_CNT_W-1:0] rx_count;
  assign rx_accept = rx_in_ready && (fifo_en || rx_count == '0);
  assign rx_push = rx_done && keep && rx_accept;
  assign rx_overrun = rx_done && keep && !rx_accept;
  uartdp_fifo #(.WIDTH(`UDP_RX_W), .DEPTH(`UDP_FIFO_DEPTH)) u_rx_fifo (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .in_data_i(rx_entry),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rhr_rd_i),
    .out_data_o(rx_head),
    .count_o(rx_count)
  );

  // Sticky line events; a new event beats a same-cycle status read
  logic oe_r;
  logic addr_evt_r;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      oe_r <= 1'b0;
      addr_evt_r <= 1'b0;
    end else begin
      oe_r <= rx_overrun || (oe_r && !lsr_rd_i);
      addr_evt_r <= (rx_push && aad_en && is_addr) || (addr_evt_r && !lsr_rd_i);
    end
  end

  // Receive timeout counts ticks of silence while data waits
  logic [11:0] to_cnt_r;
  logic [11:0] to_limit;
  logic to_flag_r;
  assign to_limit = (({9'h000, last_bit(line_control_i)} + 12'h001) * `UDP_TO_CHARS
                    + `UDP_TO_BITS) << `UDP_TO_SHIFT;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      to_cnt_r <= 12'h000;
      to_flag_r <= 1'b0;
    end else begin
      if (rx_state_r != uartdp_pkg::UDP_IDLE || rhr_rd_i || !rx_out_valid) begin
        to_cnt_r <= 12'h000;
      end else if (tick && to_cnt_r != to_limit) begin
        to_cnt_r <= to_cnt_r + 12'h001;
      end
      // Set wins over the clear by a read in the same cycle
      if (rx_out_valid && to_cnt_r == to_limit) to_flag_r <= 1'b1;
      else if (rhr_rd_i || !rx_out_valid) to_flag_r <= 1'b0;
    end
  end

  // Status assembly
  logic thre;
  logic temt;
  logic rx_ready;
  logic [7:0] trig;
  logic [7:0] lsr_nxt;
  logic [3:0] isr_nxt;
  assign thre = (tx_count == '0);
  assign temt = thre && (tx_state_r == uartdp_pkg::UDP_IDLE);
  assign trig = (rx_trigger_i == 8'h00) ? 8'h01 : rx_trigger_i;
  assign rx_ready = fifo_en ? (rx_count >= trig) : rx_out_valid;

  always_comb begin
    lsr_nxt = 8'h00;
    lsr_nxt[`UDP_LSR_DR] = rx_out_valid;
    lsr_nxt[`UDP_LSR_OE] = oe_r;
    lsr_nxt[`UDP_LSR_PE] = rx_out_valid && rx_head[`UDP_TAG_PE];
    lsr_nxt[`UDP_LSR_FE] = rx_out_valid && rx_head[`UDP_TAG_FE];
    lsr_nxt[`UDP_LSR_BI] = rx_out_valid && rx_head[`UDP_TAG_BI];
    lsr_nxt[`UDP_LSR_THRE] = thre;
    lsr_nxt[`UDP_LSR_TEMT] = temt;
  end

  // Highest priority source wins the status code
  always_comb begin
    if (interrupt_enable_i[`UDP_IER_LS] &&
        (lsr_nxt[`UDP_LSR_BI:`UDP_LSR_OE] != 4'h0 || addr_evt_r)) begin
      isr_nxt = `UDP_ISR_LS;
    end else if (interrupt_enable_i[`UDP_IER_RX] && to_flag_r) begin
      isr_nxt = `UDP_ISR_TO;
    end else if (interrupt_enable_i[`UDP_IER_RX] && rx_ready) begin
      isr_nxt = `UDP_ISR_RX;
    end else if (interrupt_enable_i[`UDP_IER_THR] && thre) begin
      isr_nxt = `UDP_ISR_THR;
    end else begin
      isr_nxt = `UDP_ISR_NONE;
    end
  end

  // IR pulse in the first 3/16 of every low bit
  logic ir_mark;
  assign ir_mark = ir_en && !tx_line && (tx_cnt_r < `UDP_IR_PULSE);

  // Output stage; every output leaves from a flop
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
      ir_tx_out_o <= 1'b0;
      direction_out_o <= 1'b0;
      dtr_o <= 1'b0;
      modem_status_o <= 4'h0;
      line_status_o <= 8'h00;
      interrupt_status_o <= `UDP_ISR_NONE;
      irq_o <= 1'b0;
      rx_holding_o <= 8'h00;
      tx_holding_ready_o <= 1'b0;
    end else begin
      tx_o <= loop_en ? 1'b1 : tx_line;
      ir_tx_out_o <= ir_control_i[`UDP_IRC_TXIDLE] ^ ir_mark;
      direction_out_o <= ((auto_en ? dir_act_r : modem_control_i[`UDP_MCR_RTS]) && !loop_en)
                         ^ (auto_en && multifunction_i[`UDP_EMF_INV]);
      dtr_o <= modem_control_i[`UDP_MCR_DTR] && !loop_en;
      modem_status_o <= loop_en ? 4'h0 : {carrier_in_i, ring_in_i, dsr_i, cts_i};
      line_status_o <= lsr_nxt;
      interrupt_status_o <= isr_nxt;
      irq_o <= (isr_nxt != `UDP_ISR_NONE);
      rx_holding_o <= rx_head[7:0];
      tx_holding_ready_o <= tx_accept;
    end
  end
endmodule : uartdp_top

// ==== hdl/uartdp_regs.svh ====
// Field positions, codes and timing counts of the UART channel datapath
`ifndef UARTDP_REGS_SVH
`define UARTDP_REGS_SVH
// Storage sizes
`define UDP_FIFO_DEPTH 128
`define UDP_TX_W 8
`define UDP_RX_W 11
`define UDP_CNT_W 8
// Bit timing at 16 samples per bit
`define UDP_OVS_LAST 4'hF
`define UDP_MID_START 4'h7
`define UDP_IR_PULSE 4'h3
`define UDP_IR_HOLD 5'h10
`define UDP_MIN_BITS 3'h4
`define UDP_TO_CHARS 12'h004
`define UDP_TO_BITS 12'h00C
`define UDP_TO_SHIFT 4
// Fifo control / line control fields
`define UDP_FCR_EN 0
`define UDP_LCR_STOP 2
`define UDP_LCR_PEN 3
`define UDP_LCR_EVEN 4
`define UDP_LCR_FORCE 5
// Interrupt enable fields
`define UDP_IER_RX 0
`define UDP_IER_THR 1
`define UDP_IER_LS 2
// Modem control fields
`define UDP_MCR_DTR 0
`define UDP_MCR_RTS 1
`define UDP_MCR_LOOP 4
// Enhanced multifunction fields
`define UDP_EMF_AUTO 4
`define UDP_EMF_INV 5
`define UDP_EMF_AAD 6
`define UDP_EMF_MDROP 7
// Infrared control fields
`define UDP_IRC_RXIDLE 0
`define UDP_IRC_TXIDLE 1
`define UDP_IRC_EN 4
// Line status fields
`define UDP_LSR_DR 0
`define UDP_LSR_OE 1
`define UDP_LSR_PE 2
`define UDP_LSR_FE 3
`define UDP_LSR_BI 4
`define UDP_LSR_THRE 5
`define UDP_LSR_TEMT 6
// Receive entry tag positions
`define UDP_TAG_PE 8
`define UDP_TAG_FE 9
`define UDP_TAG_BI 10
// Interrupt status codes, bit 0 high means nothing pending
`define UDP_ISR_NONE 4'h1
`define UDP_ISR_LS 4'h6
`define UDP_ISR_RX 4'h4
`define UDP_ISR_TO 4'hC
`define UDP_ISR_THR 4'h2
`endif

// ==== hdl/uartdp_pkg.sv ====
// Types shared by the UART channel datapath
package uartdp_pkg;
  typedef enum logic [2:0] {
    UDP_IDLE = 3'b000,
    UDP_START = 3'b001,
    UDP_DATA = 3'b010,
    UDP_PARITY = 3'b011,
    UDP_STOP = 3'b100
  } uartdp_ser_state_t;
endpackage : uartdp_pkg

// ==== hdl/uartdp_fifo.sv ====
// Parameterised first-word-fall-through FIFO with valid/ready on both sides
`timescale 1ns/1ps
module uartdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Occupancy
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full refuses the write, so queued words are never overwritten
  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign count_o = count_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage, no reset needed since empty slots are never read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers wrap explicitly so non power of two depths work
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Occupancy count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else begin
      case ({push, pop})
        2'b10: count_r <= count_r + 1'b1;
        2'b01: count_r <= count_r - 1'b1;
        default: count_r <= count_r;
      endcase
    end
  end
endmodule : uartdp_fifo

// ==== dv/uartdp_top_asserts.sv ====
// Port checker for the UART channel datapath
`timescale 1ns/1ps
module uartdp_top_asserts (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Controls
  input wire logic [7:0] modem_control_i,
  input wire logic [7:0] multifunction_i,
  input wire logic [7:0] ir_control_i,
  input wire logic [7:0] interrupt_enable_i,
  input wire logic [15:0] divisor_i,
  // Observed outputs
  input wire logic [7:0] line_status_o,
  input wire logic [3:0] interrupt_status_o,
  input wire logic irq_o,
  input wire logic tx_o,
  input wire logic ir_tx_out_o,
  input wire logic direction_out_o,
  input wire logic dtr_o,
  input wire logic [3:0] modem_status_o
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_loop_tx_mark: assert property (modem_control_i[4] [*2] |-> tx_o && !dtr_o)
    else $error("serial out or dtr active in loopback");
  a_loop_mst_zero: assert property (modem_control_i[4] [*2] |-> modem_status_o == 4'h0)
    else $error("modem inputs seen in loopback");
  a_reset_out_idle: assert property ($fell(rst_i) |-> tx_o && !direction_out_o && !irq_o)
    else $error("outputs not idle after reset");
  a_reset_tx_empty: assert property ($fell(rst_i) |=> line_status_o[6:5] == 2'b11)
    else $error("transmit empty flags not set after reset");
  a_irq_code_match: assert property (irq_o == (interrupt_status_o != 4'h1))
    else $error("irq level disagrees with status code");
  a_irq_all_masked: assert property (interrupt_enable_i[2:0] == 3'h0 [*4] |-> !irq_o)
    else $error("irq raised while all sources masked");
  a_thre_irq_on: assert property ((interrupt_enable_i[1] && line_status_o[5]) [*4] |-> irq_o)
    else $error("holding empty not signalled");
  a_temt_thre_pair: assert property (line_status_o[6] |-> line_status_o[5])
    else $error("transmitter empty while holding full");
  a_bit_min_len: assert property ($fell(tx_o) |-> !tx_o [*8])
    else $error("low serial bit too short");
  a_dir_lead_start: assert property ($fell(tx_o) && multifunction_i[4] && !multifunction_i[5]
    |-> direction_out_o && $past(direction_out_o))
    else $error("direction not raised ahead of data");
  a_ir_pulse_width: assert property ($rose(ir_tx_out_o) && ir_control_i[4] && !ir_control_i[1]
    && divisor_i == 16'h0001 |-> ir_tx_out_o [*3] ##1 !ir_tx_out_o)
    else $error("infrared pulse not three ticks wide");
endmodule : uartdp_top_asserts

bind uartdp_top uartdp_top_asserts u_chk (.core_clk_i, .rst_i, .modem_control_i,
  .multifunction_i, .ir_control_i, .interrupt_enable_i, .divisor_i, .line_status_o,
  .interrupt_status_o, .irq_o, .tx_o, .ir_tx_out_o, .direction_out_o, .dtr_o, .modem_status_o);

// ==== dv/uartdp_line_model.sv ====
// Remote station model: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module uartdp_line_model (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic tx_i,
  output logic rx_o
);
  logic [7:0] got_q[$];
  // Line rests at mark between frames and through loopback
  initial rx_o = 1'b1;
  // Start, nine bits, stop; bit 8 is the stop or the address flag
  task automatic send(input logic [8:0] d);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_o = f[i];
      repeat (16) @(posedge clk_i);
      #1;
    end
    rx_o = 1'b1;
  endtask : send
  // Short low spike that a receiver must reject
  task automatic glitch;
    rx_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    rx_o = 1'b1;
  endtask : glitch
  // Centre sampling at one tick per clock; 8N1 frames only
  always @(negedge tx_i) begin : dec
    logic [7:0] b;
    repeat (8) @(posedge clk_i);
    if (!tx_i) begin
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge clk_i);
        b[i] = tx_i;
      end
      repeat (16) @(posedge clk_i);
      if (tx_i) got_q.push_back(b);
    end
  end
endmodule : uartdp_line_model

// ==== dv/uartdp_tb_top.sv ====
// Self-checking bench for the UART channel datapath
`timescale 1ns/1ps
module uartdp_tb_top;
  logic core_clk_i, rst_i, thr_wr_i, rhr_rd_i, lsr_rd_i, rx_i, tx_o, ir_rx_in_i, ir_tx_out_o;
  logic tx_holding_ready_o, irq_o, direction_out_o, dtr_o, cts_i, dsr_i, carrier_in_i, ring_in_i;
  logic [7:0] thr_data_i, rx_holding_o, fifo_control_i, line_control_i, interrupt_enable_i;
  logic [7:0] modem_control_i, multifunction_i, ir_control_i, slave_addr_i, rx_trigger_i;
  logic [7:0] line_status_o;
  logic [15:0] divisor_i;
  logic [3:0] interrupt_status_o, modem_status_o;
  int fails, comparisons;
  uartdp_top dut (.*);
  uartdp_line_model u_line (.clk_i(core_clk_i), .tx_i(tx_o), .rx_o(rx_i));
  // 250 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  // Order: fifo, line, irq enable, modem, multifunction
  task automatic cfg(input logic [39:0] v);
    {fifo_control_i, line_control_i, interrupt_enable_i, modem_control_i, multifunction_i} = v;
    tick(2);
  endtask : cfg
  // Strobe held high across back-to-back bytes
  task automatic wr(input logic [15:0] d, input int n);
    thr_wr_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      thr_data_i = d[8*i +: 8];
      tick(1);
    end
    thr_wr_i = 1'b0;
  endtask : wr
  // Pop the head, then let the lagging holding output catch up
  task automatic rd;
    {rhr_rd_i, lsr_rd_i} = 2'b11;
    tick(1);
    {rhr_rd_i, lsr_rd_i} = 2'b00;
    tick(3);
  endtask : rd
  task automatic wait_dr(input int lim);
    for (int k = 0; k < lim && line_status_o[0] !== 1'b1; k++) tick(1);
  endtask : wait_dr
  task automatic t_tx;
    cfg(40'h01_03_02_00_10);
    wr(16'h3CA5, 2);
    check({6'h0, line_status_o[6:5]}, 8'h00);
    for (int k = 0; k < 800 && u_line.got_q.size() < 2; k++) tick(1);
    check(u_line.got_q.pop_front(), 8'hA5);
    check(u_line.got_q.pop_front(), 8'h3C);
    tick(20);
    check({6'h0, line_status_o[6:5]}, 8'h03);
    check({7'h0, direction_out_o}, 8'h00);
  endtask : t_tx
  task automatic t_rx;
    cfg(40'h01_03_00_00_00);
    u_line.glitch();
    tick(40);
    check({7'h0, line_status_o[0]}, 8'h00);
    u_line.send(9'h15A);
    wait_dr(100);
    check(rx_holding_o, 8'h5A);
    check({5'h0, line_status_o[4:2]}, 8'h00);
    rd();
    check({7'h0, line_status_o[0]}, 8'h00);
  endtask : t_rx
  task automatic t_mdrop;
    cfg(40'h01_0B_04_00_C0);
    u_line.send(9'h111);
    u_line.send(9'h022);
    u_line.send(9'h142);
    u_line.send(9'h033);
    wait_dr(100);
    check(rx_holding_o, 8'h42);
    check({7'h0, line_status_o[2]}, 8'h01);
    check({4'h0, interrupt_status_o}, 8'h06);
    rd();
    check(rx_holding_o, 8'h33);
    check({7'h0, line_status_o[2]}, 8'h00);
    rd();
    check({7'h0, line_status_o[0]}, 8'h00);
  endtask : t_mdrop
  task automatic t_timeout;
    cfg(40'h01_03_01_00_00);
    u_line.send(9'h1C3);
    tick(640);
    check({4'h0, interrupt_status_o}, 8'h01);
    tick(100);
    check({4'h0, interrupt_status_o}, 8'h0C);
    rd();
  endtask : t_timeout
  task automatic t_loop;
    // Dtr and rts requested, so loopback really has something to hold off
    cfg(40'h00_03_00_13_00);
    {cts_i, dsr_i, carrier_in_i, ring_in_i} = 4'hA;
    wr(16'h5596, 2);
    check({7'h0, tx_holding_ready_o}, 8'h00);
    tick(7);
    check({6'h0, line_status_o[6:5]}, 8'h01);
    check({4'h0, modem_status_o}, 8'h00);
    check({6'h0, dtr_o, direction_out_o}, 8'h00);
    wait_dr(400);
    check(rx_holding_o, 8'h96);
    rd();
    // The refused second byte must never come back round
    tick(200);
    check({7'h0, line_status_o[0]}, 8'h00);
    cfg(40'h01_03_00_03_00);
    check({4'h0, modem_status_o}, 8'h09);
    check({6'h0, dtr_o, direction_out_o}, 8'h03);
    // Two light pulses one bit apart: start bit and a zero bit 0
    ir_control_i = 8'h10;
    for (int i = 0; i < 2; i++) begin
      ir_rx_in_i = 1'b1;
      tick(1);
      ir_rx_in_i = 1'b0;
      tick(15);
    end
    wait_dr(300);
    check(rx_holding_o, 8'hFE);
    rd();
    wr(16'h0000, 1);
    tick(200);
    ir_control_i = 8'h02;
    tick(2);
    check({7'h0, ir_tx_out_o}, 8'h01);
    ir_control_i = 8'h00;
  endtask : t_loop
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk_i);
    fails++;
    give_verdict();
  end
  // Reset, then the scenarios in turn
  initial begin
    {thr_wr_i, rhr_rd_i, lsr_rd_i, ir_rx_in_i, rst_i} = 5'h01;
    {cts_i, dsr_i, carrier_in_i, ring_in_i} = 4'hF;
    {thr_data_i, ir_control_i, slave_addr_i, rx_trigger_i} = 32'h0000_4208;
    {fifo_control_i, line_control_i, interrupt_enable_i, modem_control_i} = 32'h0103_0000;
    multifunction_i = 8'h00;
    divisor_i = 16'h0001;
    repeat (5) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    tick(1);
    check(line_status_o, 8'h60);
    t_tx();
    t_rx();
    t_mdrop();
    t_timeout();
    t_loop();
    give_verdict();
  end
endmodule : uartdp_tb_top
